// *** accel_pm_pkg.sv ***
// Shared constants, register map and state types for the mode and power controller
package accel_pm_pkg;
   localparam int CLK_PERIOD_NS   = 40;
   localparam int POR_MAX_US      = 350;
   localparam int POR_CYCLES      = (POR_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int RELOAD_US       = 100;
   localparam int RELOAD_CYCLES   = (RELOAD_US * 1000) / CLK_PERIOD_NS;
   localparam int NAP_UNIT_US     = 500;
   localparam int NAP_UNIT_CYCLES = (NAP_UNIT_US * 1000) / CLK_PERIOD_NS;
   localparam int TIMER_W         = 20;
   localparam int SAMPLE_BYTES    = 6;

   localparam logic [5:0] SLAVE_ADDR_HIGH  = 6'h09;
   localparam logic [7:0] REG_DATA_FIRST   = 8'h01;
   localparam logic [7:0] REG_DATA_LAST    = 8'h06;
   localparam logic [7:0] REG_MODE_SLEEP   = 8'h11;
   localparam logic [7:0] REG_SELF_CHECK   = 8'h32;
   localparam logic [7:0] REG_IMAGE_RELOAD = 8'h33;
   localparam logic [7:0] REG_FULL_RESET   = 8'h36;
   localparam logic [7:0] REG_TRIM_IMAGE   = 8'h38;
   localparam logic [7:0] REG_SAMPLE_QUEUE = 8'h3f;

   localparam int MODE_BIT        = 7;
   localparam int NAP_MSB         = 3;
   localparam int SELF_DRIVE_BIT  = 7;
   localparam int SELF_NEG_BIT    = 2;
   localparam int RELOAD_REQ_BIT  = 3;
   localparam int RELOAD_DONE_BIT = 2;

   localparam logic [7:0] FULL_RESET_CODE  = 8'hb6;
   localparam logic [7:0] REG_RESET_VALUE  = 8'h00;
   localparam logic [3:0] NAP_CONTINUOUS   = 4'h0;
   localparam logic [3:0] BYTE_BITS        = 4'h8;

   typedef enum logic [2:0] {
      PM_POR_LOAD = 3'b000,
      PM_STANDBY  = 3'b001,
      PM_RUN      = 3'b010,
      PM_SLEEP    = 3'b011,
      PM_RELOAD   = 3'b100
   } power_state_t;

   typedef enum logic [2:0] {
      BUS_IDLE     = 3'b000,
      BUS_ADDR     = 3'b001,
      BUS_ADDR_ACK = 3'b010,
      BUS_RX       = 3'b011,
      BUS_RX_ACK   = 3'b100,
      BUS_TX       = 3'b101,
      BUS_TX_ACK   = 3'b110
   } bus_state_t;
endpackage

// *** pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
   parameter int         W         = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   // First stage feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
      end else begin
         s1_reg <= d_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A bit changes only once two stages agree
   always_ff @(posedge clk) begin
      if (rst) begin
         q_out <= RESET_VAL;
      end else begin
         q_out <= (s2_reg & s3_reg) | (q_out & (s2_reg ^ s3_reg));
      end
   end
endmodule

// *** i2c_reg_slave.sv ***
// Two-wire bus slave with register pointer and auto increment
`timescale 1ns/1ps
module i2c_reg_slave (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       bus_enable,
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       addr_lsb,
   input  wire logic [7:0] rd_data,
   output logic            sda_low,
   output logic            wr_stb,
   output logic      [7:0] wr_addr,
   output logic      [7:0] wr_data,
   output logic            rd_stb,
   output logic      [7:0] rd_addr
);
   import accel_pm_pkg::*;

   bus_state_t state_reg;
   logic       scl_reg;
   logic       sda_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [7:0] ptr_reg;
   logic [3:0] count_reg;
   logic       rw_reg;
   logic       first_reg;
   logic       nack_reg;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_cond;
   logic       stop_cond;

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end else begin
         scl_reg <= scl;
         sda_reg <= sda;
      end
   end

   assign scl_rise   = scl & ~scl_reg;
   assign scl_fall   = ~scl & scl_reg;
   assign start_cond = scl & scl_reg & sda_reg & ~sda;
   assign stop_cond  = scl & scl_reg & ~sda_reg & sda;
   assign rd_addr    = ptr_reg;

   always_ff @(posedge clk) begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (rst || !bus_enable) begin
         state_reg <= BUS_IDLE;
         sda_low   <= 1'b0;
         shift_reg <= 8'h00;
         tx_reg    <= 8'h00;
         ptr_reg   <= 8'h00;
         count_reg <= 4'h0;
         rw_reg    <= 1'b0;
         first_reg <= 1'b0;
         nack_reg  <= 1'b1;
         wr_addr   <= 8'h00;
         wr_data   <= 8'h00;
      end else if (start_cond) begin
         state_reg <= BUS_ADDR;
         count_reg <= 4'h0;
         sda_low   <= 1'b0;
      end else if (stop_cond) begin
         state_reg <= BUS_IDLE;
         sda_low   <= 1'b0;
      end else if (scl_rise) begin
         case (state_reg)
            BUS_ADDR, BUS_RX: begin
               shift_reg <= {shift_reg[6:0], sda};
               count_reg <= count_reg + 4'h1;
            end
            BUS_TX: begin
               count_reg <= count_reg + 4'h1;
            end
            BUS_TX_ACK: begin
               nack_reg <= sda;
               if (!sda) begin
                  ptr_reg <= ptr_reg + 8'h01;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (state_reg)
            BUS_ADDR: begin
               if (count_reg == BYTE_BITS) begin
                  count_reg <= 4'h0;
                  if (shift_reg[7:1] == {SLAVE_ADDR_HIGH, addr_lsb}) begin
                     sda_low   <= 1'b1;
                     rw_reg    <= shift_reg[0];
                     first_reg <= 1'b1;
                     state_reg <= BUS_ADDR_ACK;
                  end else begin
                     state_reg <= BUS_IDLE;
                  end
               end
            end
            BUS_ADDR_ACK: begin
               count_reg <= 4'h0;
               if (rw_reg) begin
                  tx_reg    <= rd_data;
                  rd_stb    <= 1'b1;
                  sda_low   <= ~rd_data[7];
                  state_reg <= BUS_TX;
               end else begin
                  sda_low   <= 1'b0;
                  state_reg <= BUS_RX;
               end
            end
            BUS_RX: begin
               if (count_reg == BYTE_BITS) begin
                  count_reg <= 4'h0;
                  sda_low   <= 1'b1;
                  first_reg <= 1'b0;
                  state_reg <= BUS_RX_ACK;
                  if (first_reg) begin
                     ptr_reg <= shift_reg;
                  end else begin
                     wr_stb  <= 1'b1;
                     wr_addr <= ptr_reg;
                     wr_data <= shift_reg;
                     ptr_reg <= ptr_reg + 8'h01;
                  end
               end
            end
            BUS_RX_ACK: begin
               sda_low   <= 1'b0;
               state_reg <= BUS_RX;
            end
            BUS_TX: begin
               if (count_reg == BYTE_BITS) begin
                  sda_low   <= 1'b0;
                  state_reg <= BUS_TX_ACK;
               end else begin
                  tx_reg  <= {tx_reg[6:0], 1'b0};
                  sda_low <= ~tx_reg[6];
               end
            end
            BUS_TX_ACK: begin
               count_reg <= 4'h0;
               if (nack_reg) begin
                  state_reg <= BUS_IDLE;
               end else begin
                  tx_reg    <= rd_data;
                  rd_stb    <= 1'b1;
                  sda_low   <= ~rd_data[7];
                  state_reg <= BUS_TX;
               end
            end
            default: begin
               state_reg <= BUS_IDLE;
            end
         endcase
      end
   end
endmodule

// *** accel_mode_power_control.sv ***
// Mode, power state and image reload control with its register file
// Functional notes
// - Reset clears all registers to defaults, then the core settles in standby.
// - Power-on reset with trim transfer ends within 350 us, then bus accepted.
// - Bus address is 001001 followed by the address select pin level.
// - Slave runs at 100 kHz and 400 kHz; the host model clocks one bit per 8 system cycles, far faster.
// - Bit 7 of 0x11 picks active (one) or standby (zero).
// - Standby powers down the signal chain but keeps the bus usable.
// - Writing 0xB6 to 0x36 restores defaults and enters standby from any mode.
// - Run state converts and stores results in 0x01 to 0x06 and 0x3F.
// - After each conversion a sleep set by 0x11 bits 3:0 follows.
// - Sleep field of zero gives back-to-back continuous conversion.
// - Sleep state turns off the whole conditioning chain.
// - In active mode 0x32 bit 7 applies self-check force, bit 2 negates it.
// - Writing 0x33 bit 3 in active mode reloads only the image register.
// - Ready flag 0x33 bit 2 is low during reload; request self-clears after.
// - A request written in standby waits until active mode is entered.
// - Reload lasts about 100 us, then the core goes to standby.
// - All logic runs on the internal clock, never driven out.
`timescale 1ns/1ps
module accel_mode_power_control #(
   parameter int POR_WAIT_CYCLES = accel_pm_pkg::POR_CYCLES,
   parameter int NAP_UNIT        = accel_pm_pkg::NAP_UNIT_CYCLES
) (
   input  wire logic                       CLK,
   input  wire logic                       RST,
   input  wire logic                       SCL_PIN,
   input  wire logic                       SDA_PIN_IN,
   output logic                            SDA_PIN_OUT,
   output logic                            SDA_PIN_OE_N,
   input  wire logic                       ADDRESS_LOW_SELECT,
   input  wire logic                       CONV_DONE,
   input  wire logic [8*accel_pm_pkg::SAMPLE_BYTES-1:0] SAMPLE_DATA,
   input  wire logic [7:0]                 TRIM_STORE,
   output logic                            ANALOG_ON,
   output logic                            CONV_START,
   output logic                            SELF_CHECK_DRIVE,
   output logic                            SELF_CHECK_NEGATIVE,
   output logic                            ACTIVE_MODE,
   output logic [7:0]                      TRIM_IMAGE
);
   import accel_pm_pkg::*;

   power_state_t state_reg;
   logic [TIMER_W-1:0] timer_reg;
   logic [7:0]  mode_sleep_reg;
   logic [7:0]  self_check_reg;
   logic        reload_req_reg;
   logic        reload_done_reg;
   logic        por_done_reg;
   logic [7:0]  sample_reg [SAMPLE_BYTES];
   logic [2:0]  queue_idx_reg;
   logic [2:0]  scl_sda_addr;
   logic        scl_s;
   logic        sda_s;
   logic        addr_s;
   logic        sda_low;
   logic        wr_stb;
   logic [7:0]  wr_addr;
   logic [7:0]  wr_data;
   logic        rd_stb;
   logic [7:0]  rd_addr;
   logic [7:0]  rd_data;
   logic        full_reset;
   logic        timer_zero;
   logic        reload_finish;
   logic        por_finish;
   logic        mode_active;
   logic [3:0]  nap_length_field;
   logic        reload_req_write;

   // Pins arrive from the host's domain
   pin_sync #(
      .W         (3),
      .RESET_VAL (3'h7)
   ) u_pin_sync (
      .clk   (CLK),
      .rst   (RST),
      .d_in  ({SCL_PIN, SDA_PIN_IN, ADDRESS_LOW_SELECT}),
      .q_out (scl_sda_addr)
   );

   assign scl_s  = scl_sda_addr[2];
   assign sda_s  = scl_sda_addr[1];
   assign addr_s = scl_sda_addr[0];

   // Filtered edges leave ample margin at 400 kHz
   i2c_reg_slave u_slave (
      .clk        (CLK),
      .rst        (RST),
      .bus_enable (por_done_reg),
      .scl        (scl_s),
      .sda        (sda_s),
      .addr_lsb   (addr_s),
      .rd_data    (rd_data),
      .sda_low    (sda_low),
      .wr_stb     (wr_stb),
      .wr_addr    (wr_addr),
      .wr_data    (wr_data),
      .rd_stb     (rd_stb),
      .rd_addr    (rd_addr)
   );

   // Open drain: only ever pulls low; the clock pin is input only
   assign SDA_PIN_OUT  = 1'b0;
   assign SDA_PIN_OE_N = ~sda_low;

   assign mode_active      = mode_sleep_reg[MODE_BIT];
   assign nap_length_field = mode_sleep_reg[NAP_MSB:0];
   assign timer_zero       = (timer_reg == '0);
   assign por_finish       = (state_reg == PM_POR_LOAD) && timer_zero;
   assign reload_finish    = (state_reg == PM_RELOAD) && timer_zero;
   assign full_reset       = wr_stb && (wr_addr == REG_FULL_RESET) && (wr_data == FULL_RESET_CODE);
   assign reload_req_write = wr_stb && (wr_addr == REG_IMAGE_RELOAD);

   // Power state sequencing
   always_ff @(posedge CLK) begin
      CONV_START <= 1'b0;
      if (RST) begin
         state_reg <= PM_POR_LOAD;
         timer_reg <= TIMER_W'(POR_WAIT_CYCLES - 1);
      end else if (state_reg == PM_POR_LOAD) begin
         if (timer_zero) begin
            state_reg <= PM_STANDBY;
         end else begin
            timer_reg <= timer_reg - 1'b1;
         end
      end else if (full_reset) begin
         state_reg <= PM_STANDBY;
      end else begin
         case (state_reg)
            PM_STANDBY: begin
               if (mode_active) begin
                  if (reload_req_reg) begin
                     state_reg <= PM_RELOAD;
                     timer_reg <= TIMER_W'(RELOAD_CYCLES - 1);
                  end else begin
                     state_reg  <= PM_RUN;
                     CONV_START <= 1'b1;
                  end
               end
            end
            PM_RUN: begin
               if (!mode_active) begin
                  state_reg <= PM_STANDBY;
               end else if (reload_req_reg) begin
                  state_reg <= PM_RELOAD;
                  timer_reg <= TIMER_W'(RELOAD_CYCLES - 1);
               end else if (CONV_DONE) begin
                  if (nap_length_field == NAP_CONTINUOUS) begin
                     CONV_START <= 1'b1;
                  end else begin
                     state_reg <= PM_SLEEP;
                     timer_reg <= TIMER_W'(int'(nap_length_field) * NAP_UNIT - 1);
                  end
               end
            end
            PM_SLEEP: begin
               if (!mode_active) begin
                  state_reg <= PM_STANDBY;
               end else if (reload_req_reg) begin
                  state_reg <= PM_RELOAD;
                  timer_reg <= TIMER_W'(RELOAD_CYCLES - 1);
               end else if (timer_zero) begin
                  state_reg  <= PM_RUN;
                  CONV_START <= 1'b1;
               end else begin
                  timer_reg <= timer_reg - 1'b1;
               end
            end
            PM_RELOAD: begin
               if (timer_zero) begin
                  state_reg <= PM_STANDBY;
               end else begin
                  timer_reg <= timer_reg - 1'b1;
               end
            end
            default: begin
               state_reg <= PM_STANDBY;
            end
         endcase
      end
   end

   // Bus stays deaf until trim transfer completes
   always_ff @(posedge CLK) begin
      if (RST) begin
         por_done_reg <= 1'b0;
      end else if (por_finish) begin
         por_done_reg <= 1'b1;
      end
   end

   // Mode and sleep control
   always_ff @(posedge CLK) begin
      if (RST || full_reset) begin
         mode_sleep_reg <= REG_RESET_VALUE;
      end else if (wr_stb && wr_addr == REG_MODE_SLEEP) begin
         mode_sleep_reg <= wr_data;
      end else if (reload_finish) begin
         mode_sleep_reg[MODE_BIT] <= 1'b0;
      end
   end

   // Self-check control
   always_ff @(posedge CLK) begin
      if (RST || full_reset) begin
         self_check_reg <= REG_RESET_VALUE;
      end else if (wr_stb && wr_addr == REG_SELF_CHECK) begin
         self_check_reg <= wr_data;
      end
   end

   // Request: a software set in the finishing cycle wins over the self-clear
   always_ff @(posedge CLK) begin
      if (RST || full_reset) begin
         reload_req_reg <= 1'b0;
      end else if (reload_req_write) begin
         reload_req_reg <= wr_data[RELOAD_REQ_BIT];
      end else if (reload_finish) begin
         reload_req_reg <= 1'b0;
      end
   end

   // Ready flag and image register
   always_ff @(posedge CLK) begin
      if (RST) begin
         reload_done_reg <= 1'b0;
         TRIM_IMAGE      <= REG_RESET_VALUE;
      end else if (por_finish || reload_finish) begin
         reload_done_reg <= 1'b1;
         TRIM_IMAGE      <= TRIM_STORE;
      end else if (state_reg == PM_RELOAD) begin
         reload_done_reg <= 1'b0;
      end
   end

   // Results captured only while converting
   always_ff @(posedge CLK) begin
      if (RST || full_reset) begin
         for (int i = 0; i < SAMPLE_BYTES; i++) begin
            sample_reg[i] <= REG_RESET_VALUE;
         end
      end else if (state_reg == PM_RUN && CONV_DONE) begin
         for (int i = 0; i < SAMPLE_BYTES; i++) begin
            sample_reg[i] <= SAMPLE_DATA[8*i +: 8];
         end
      end
   end

   // Queue port walks the latest sample; no deeper storage kept
   always_ff @(posedge CLK) begin
      if (RST || full_reset) begin
         queue_idx_reg <= 3'h0;
      end else if (state_reg == PM_RUN && CONV_DONE) begin
         queue_idx_reg <= 3'h0;
      end else if (rd_stb && rd_addr == REG_SAMPLE_QUEUE) begin
         if (queue_idx_reg == 3'(SAMPLE_BYTES - 1)) begin
            queue_idx_reg <= 3'h0;
         end else begin
            queue_idx_reg <= queue_idx_reg + 3'h1;
         end
      end
   end

   // Register read mux
   always_comb begin
      rd_data = REG_RESET_VALUE;
      if (rd_addr >= REG_DATA_FIRST && rd_addr <= REG_DATA_LAST) begin
         rd_data = sample_reg[3'(rd_addr - REG_DATA_FIRST)];
      end else begin
         case (rd_addr)
            REG_MODE_SLEEP:   rd_data = mode_sleep_reg;
            REG_SELF_CHECK:   rd_data = self_check_reg;
            REG_IMAGE_RELOAD: begin
               rd_data[RELOAD_REQ_BIT]  = reload_req_reg;
               rd_data[RELOAD_DONE_BIT] = reload_done_reg;
            end
            REG_TRIM_IMAGE:   rd_data = TRIM_IMAGE;
            REG_SAMPLE_QUEUE: rd_data = sample_reg[queue_idx_reg];
            default:          rd_data = REG_RESET_VALUE;
         endcase
      end
   end

   // Chain powered only in run; sleep and standby keep it off
   assign ANALOG_ON           = (state_reg == PM_RUN);
   assign ACTIVE_MODE         = (state_reg == PM_RUN) || (state_reg == PM_SLEEP);
   assign SELF_CHECK_DRIVE    = ACTIVE_MODE && self_check_reg[SELF_DRIVE_BIT];
   assign SELF_CHECK_NEGATIVE = ACTIVE_MODE && self_check_reg[SELF_DRIVE_BIT]
                                && self_check_reg[SELF_NEG_BIT];
endmodule

// *** i2c_host_model.sv ***
// Bus host model that bit-bangs the two-wire link from the system clock
`timescale 1ns/1ps
module i2c_host_model (
   input  wire logic CLK,
   input  wire logic SDA_W,
   output logic      SCL,
   output logic      SDA_LOW
);
   // Idle bus: clock stands high, data released to the pull-up
   initial begin
      SCL = 1'b1;
      SDA_LOW = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge CLK);
   endtask
   // Also serves as repeated start
   task automatic start();
      wt(2);
      SDA_LOW <= 1'b0;
      wt(4);
      SCL <= 1'b1;
      wt(4);
      SDA_LOW <= 1'b1;
      wt(4);
      SCL <= 1'b0;
   endtask
   task automatic stop();
      wt(2);
      SDA_LOW <= 1'b1;
      wt(2);
      SCL <= 1'b1;
      wt(4);
      SDA_LOW <= 1'b0;
      wt(4);
   endtask
   // Data moves mid-low; wire sampled late in the high phase to allow for the slave's sync delay
   task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
      logic [8:0] s;
      s = {d, a};
      for (int i = 8; i >= 0; i--) begin
         wt(2);
         SDA_LOW <= ~s[i];
         wt(3);
         SCL <= 1'b1;
         wt(3);
         s[i] = SDA_W;
         SCL <= 1'b0;
      end
      q = s[8:1];
      ack = s[0];
   endtask
endmodule

// *** accel_mode_power_control_chk.sv ***
// Port checker for the mode and power controller
`timescale 1ns/1ps
module accel_mode_power_control_chk #(
   parameter int POR_WAIT_CYCLES = 20,
   parameter int NAP_UNIT        = 5
) (
   input wire logic       CLK,
   input wire logic       RST,
   input wire logic       SDA_PIN_OUT,
   input wire logic       SDA_PIN_OE_N,
   input wire logic       CONV_DONE,
   input wire logic       ANALOG_ON,
   input wire logic       CONV_START,
   input wire logic       SELF_CHECK_DRIVE,
   input wire logic       SELF_CHECK_NEGATIVE,
   input wire logic       ACTIVE_MODE,
   input wire logic [7:0] TRIM_IMAGE
);
   int por_cnt_reg;
   int nap_cnt_reg;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   always_ff @(posedge CLK) begin
      if (RST) por_cnt_reg <= 0;
      else if (por_cnt_reg < POR_WAIT_CYCLES) por_cnt_reg <= por_cnt_reg + 1;
   end
   // Sleep cycles inside active mode; cleared in run so each nap is measured alone
   always_ff @(posedge CLK) begin
      if (RST || !ACTIVE_MODE || ANALOG_ON) nap_cnt_reg <= 0;
      else nap_cnt_reg <= nap_cnt_reg + 1;
   end
   AST_NO_EARLY_ACK: assert property (por_cnt_reg < POR_WAIT_CYCLES |-> SDA_PIN_OE_N && !ACTIVE_MODE)
      else $error("bus answered or core active before power-on reset ended");
   AST_OPEN_DRAIN: assert property (SDA_PIN_OUT == 1'b0)
      else $error("data pin driven high");
   AST_TRIM_QUIET: assert property ($changed(TRIM_IMAGE) |-> !ACTIVE_MODE && !$past(ACTIVE_MODE))
      else $error("trim image changed while active");
   AST_ONE_SHOT: assert property (CONV_START |=> !CONV_START)
      else $error("conversion start longer than one cycle");
   AST_WAKE_START: assert property ($rose(ANALOG_ON) |-> ##[0:1] CONV_START)
      else $error("run entered without a conversion start");
   AST_DONE_NEXT: assert property (CONV_DONE && ANALOG_ON |-> ##[1:3] (CONV_START || !ANALOG_ON))
      else $error("no restart and no sleep after conversion");
   AST_NAP_SPAN: assert property ($rose(ANALOG_ON) && $past(ACTIVE_MODE) |-> nap_cnt_reg >= NAP_UNIT)
      else $error("sleep shorter than one nap unit");
   AST_ANALOG_GATE: assert property (ANALOG_ON |-> ACTIVE_MODE)
      else $error("signal chain on outside active mode");
   AST_SELF_GATE: assert property (SELF_CHECK_DRIVE |-> ACTIVE_MODE)
      else $error("self-check force outside active mode");
   AST_SIGN_GATE: assert property (SELF_CHECK_NEGATIVE |-> SELF_CHECK_DRIVE)
      else $error("negative force without self-check");
   cover property (CONV_DONE ##[1:3] CONV_START);
   cover property ($fell(ANALOG_ON) && ACTIVE_MODE);
   cover property ($changed(TRIM_IMAGE) && !$past(RST));
   cover property (SELF_CHECK_NEGATIVE);
endmodule
bind accel_mode_power_control accel_mode_power_control_chk #(
   .POR_WAIT_CYCLES(POR_WAIT_CYCLES), .NAP_UNIT(NAP_UNIT)
) u_chk (
   .CLK(CLK), .RST(RST), .SDA_PIN_OUT(SDA_PIN_OUT), .SDA_PIN_OE_N(SDA_PIN_OE_N),
   .CONV_DONE(CONV_DONE), .ANALOG_ON(ANALOG_ON), .CONV_START(CONV_START),
   .SELF_CHECK_DRIVE(SELF_CHECK_DRIVE), .SELF_CHECK_NEGATIVE(SELF_CHECK_NEGATIVE),
   .ACTIVE_MODE(ACTIVE_MODE), .TRIM_IMAGE(TRIM_IMAGE)
);

// *** tb_accel_mode_power_control.sv ***
// Testbench for the mode and power controller
`timescale 1ns/1ps
module tb_accel_mode_power_control;
   import accel_pm_pkg::*;
   localparam int POR_W = 200;
   localparam int NAP_W = 5;
   logic        clk;
   logic        rst;
   logic        als;
   logic        conv_done;
   logic [47:0] sample;
   logic [7:0]  trim_st;
   logic [6:0]  dev;
   wire         scl;
   wire         host_low;
   wire         sda_w;
   wire         sda_out;
   wire         sda_oe_n;
   wire         analog_on;
   wire         conv_start;
   wire         drv;
   wire         neg;
   wire         active;
   wire  [7:0]  trim;
   int          err_count;
   int          cmp_count;
   // Pull-up wins unless a party pulls low
   assign sda_w = ~(host_low | ~sda_oe_n);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   i2c_host_model u_i2c_host_model (.CLK(clk), .SDA_W(sda_w), .SCL(scl), .SDA_LOW(host_low));
   accel_mode_power_control #(.POR_WAIT_CYCLES(POR_W), .NAP_UNIT(NAP_W)) u_accel_mode_power_control (
      .CLK(clk), .RST(rst), .SCL_PIN(scl), .SDA_PIN_IN(sda_w), .SDA_PIN_OUT(sda_out),
      .SDA_PIN_OE_N(sda_oe_n), .ADDRESS_LOW_SELECT(als), .CONV_DONE(conv_done),
      .SAMPLE_DATA(sample), .TRIM_STORE(trim_st), .ANALOG_ON(analog_on), .CONV_START(conv_start),
      .SELF_CHECK_DRIVE(drv), .SELF_CHECK_NEGATIVE(neg), .ACTIVE_MODE(active), .TRIM_IMAGE(trim));
   task print_verdict();
      $display("compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task snd(input logic [7:0] d, input logic e);
      logic [7:0] x;
      logic       k;
      u_i2c_host_model.byte_io(d, 1'b1, x, k);
      chk({7'h00, k}, {7'h00, e});
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      u_i2c_host_model.start();
      snd({dev, 1'b0}, 1'b0);
      snd(a, 1'b0);
      snd(d, 1'b0);
      u_i2c_host_model.stop();
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      logic       k;
      u_i2c_host_model.start();
      snd({dev, 1'b0}, 1'b0);
      snd(a, 1'b0);
      u_i2c_host_model.start();
      snd({dev, 1'b1}, 1'b0);
      u_i2c_host_model.byte_io(8'hff, 1'b1, q, k);
      u_i2c_host_model.stop();
      chk(q, e);
   endtask
   task pulse();
      @(posedge clk) conv_done <= 1'b1;
      @(posedge clk) conv_done <= 1'b0;
   endtask
   // Bounded wait for a conversion start
   task wcs(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         if (conv_start === 1'b1) return;
      end
      err_count++;
      print_verdict();
   endtask
   initial begin
      rst = 1'b1;
      als = 1'b1;
      conv_done = 1'b0;
      sample = 48'h665544332211;
      trim_st = 8'h5a;
      dev = {SLAVE_ADDR_HIGH, 1'b1};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      // Address sent while power-on reset still runs
      u_i2c_host_model.start();
      snd({dev, 1'b0}, 1'b1);
      u_i2c_host_model.stop();
      repeat (POR_W) @(posedge clk);
      chk(trim, 8'h5a);
      rd(REG_IMAGE_RELOAD, 8'h04);
      rd(REG_MODE_SLEEP, 8'h00);
      chk({7'h00, active}, 8'h00);
      $display("power-up test done");
      u_i2c_host_model.start();
      snd({SLAVE_ADDR_HIGH, 2'b00}, 1'b1);
      u_i2c_host_model.stop();
      @(posedge clk) als <= 1'b0;
      dev = {SLAVE_ADDR_HIGH, 1'b0};
      repeat (8) @(posedge clk);
      rd(REG_SELF_CHECK, 8'h00);
      rd(8'h20, 8'h00);
      $display("address test done");
      wr(REG_MODE_SLEEP, 8'h80);
      chk({7'h00, active}, 8'h01);
      pulse();
      wcs(4);
      for (int i = 1; i <= 6; i++) rd(8'(i), 8'(i * 17));
      rd(REG_SAMPLE_QUEUE, 8'h11);
      rd(REG_SAMPLE_QUEUE, 8'h22);
      wr(REG_SELF_CHECK, 8'h84);
      chk({6'h00, drv, neg}, 8'h03);
      sample[7:0] <= 8'h4d;
      pulse();
      rd(8'h01, 8'h4d);
      wr(REG_SELF_CHECK, 8'h00);
      chk({6'h00, drv, neg}, 8'h00);
      wr(REG_MODE_SLEEP, 8'h82);
      pulse();
      repeat (2) @(posedge clk);
      chk({7'h00, analog_on}, 8'h00);
      wcs(40);
      $display("active test done");
      wr(REG_MODE_SLEEP, 8'h00);
      wr(REG_SELF_CHECK, 8'h84);
      chk({5'h00, active, drv, neg}, 8'h00);
      wr(REG_IMAGE_RELOAD, 8'h08);
      @(posedge clk) trim_st <= 8'ha5;
      rd(REG_IMAGE_RELOAD, 8'h0c);
      chk(trim, 8'h5a);
      wr(REG_MODE_SLEEP, 8'h80);
      rd(REG_IMAGE_RELOAD, 8'h08);
      repeat (RELOAD_CYCLES) @(posedge clk);
      rd(REG_IMAGE_RELOAD, 8'h04);
      rd(REG_MODE_SLEEP, 8'h00);
      chk(trim, 8'ha5);
      rd(REG_SELF_CHECK, 8'h84);
      wr(REG_MODE_SLEEP, 8'h80);
      trim_st <= 8'h3c;
      wr(REG_IMAGE_RELOAD, 8'h08);
      repeat (RELOAD_CYCLES) @(posedge clk);
      chk(trim, 8'h3c);
      $display("reload test done");
      wr(REG_MODE_SLEEP, 8'h83);
      wr(REG_FULL_RESET, FULL_RESET_CODE);
      rd(REG_MODE_SLEEP, 8'h00);
      rd(REG_SELF_CHECK, 8'h00);
      rd(REG_FULL_RESET, 8'h00);
      rd(REG_IMAGE_RELOAD, 8'h04);
      chk({7'h00, active}, 8'h00);
      chk(trim, 8'h3c);
      $display("full reset test done");
      print_verdict();
   end
endmodule
